// *** hdl/eb_pkg.sv ***
// ==========================================================================
// Shared constants for the engine-brake level control.
// ==========================================================================
package eb_pkg;

	// ======================================================================
	// Permission thresholds.
	// ======================================================================
	// Engine speed must be above this figure, in rpm.
	localparam int          RPM_MIN       = 800;
	// Accelerator position must be below this figure, in percent.
	localparam logic [7:0]  PEDAL_MAX_PCT = 8'h07;
	// Vehicle speed that counts as standing still, in mph.
	localparam int          SPEED_STILL   = 0;

	// ======================================================================
	// Brake levels and the solenoid pattern for each.
	// ======================================================================
	localparam logic [1:0]  LVL_OFF  = 2'h0;
	localparam logic [1:0]  LVL_LOW  = 2'h1;
	localparam logic [1:0]  LVL_MED  = 2'h2;
	localparam logic [1:0]  LVL_HIGH = 2'h3;

	localparam logic [2:0]  SOL_OFF  = 3'h0;
	localparam logic [2:0]  SOL_LOW  = 3'h1;
	localparam logic [2:0]  SOL_MED  = 3'h3;
	localparam logic [2:0]  SOL_HIGH = 3'h7;

	// ======================================================================
	// Brake-initiation modes while the cruise switch is on.
	// ======================================================================
	localparam logic [1:0]  MODE_FOLLOW = 2'h0;
	localparam logic [1:0]  MODE_HOLD   = 2'h1;
	localparam logic [1:0]  MODE_SWITCH = 2'h2;

	// Auxiliary drive configuration code for none selected.
	localparam logic [1:0]  AUX_CFG_NONE = 2'h0;

	// ======================================================================
	// State of the brake-triggered hold latch.
	// ======================================================================
	typedef enum logic [1:0]
	{
		HOLD_IDLE = 2'h1,
		HOLD_SET  = 2'h2
	} hold_st_t;

endpackage

// *** hdl/engage_delay.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Engagement delay: counts control ticks while a request stands.
// ==========================================================================
module engage_delay
#(
	parameter int DLY_W = 8
)
(
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Control tick.
	input  wire logic             tick,
	// Request and delay in ticks.
	input  wire logic             want,
	input  wire logic [DLY_W-1:0] delay,
	// Request has waited long enough.
	output logic                  fire
);

	logic [DLY_W-1:0] cnt_ff;

	// A zero-width count could not hold any delay.
	if (DLY_W < 1)
		$error("DLY_W must be positive");

	// ======================================================================
	// Tick counter.
	// ======================================================================
	// A dropped request clears the count, so each new request waits the
	// whole delay again; release itself is never delayed.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cnt_ff <= '0;
		else if (tick && !want)
			cnt_ff <= '0;
		else if (tick && cnt_ff < delay)
			cnt_ff <= cnt_ff + 1'b1;
	end

	// The count saturates at the delay, so a later shorter delay still fires.
	assign fire = want && (cnt_ff >= delay);

endmodule

// *** hdl/brake_level_ctrl.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Engine-brake level control.
// ==========================================================================
module brake_level_ctrl
#(
	parameter int RPM_W = 16,
	parameter int SPD_W = 8,
	parameter int DLY_W = 8
)
(
	// Clock, reset and control tick.
	input  wire logic             REF_CLK,
	input  wire logic             RST_N,
	input  wire logic             TICK,
	// Cab level switches, high when shorted to sensor common.
	input  wire logic             SW_LOW_SHORT,
	input  wire logic             SW_MED_SHORT,
	// Engine and pedal state.
	input  wire logic [RPM_W-1:0] ENGINE_RPM,
	input  wire logic [7:0]       PEDAL_PCT,
	input  wire logic             CLUTCH_PRESSED,
	input  wire logic             SERVICE_BRAKE,
	input  wire logic             FUELING,
	// Vehicle and cruise state.
	input  wire logic [SPD_W-1:0] VEH_SPEED,
	input  wire logic             CRUISE_SW_ON,
	input  wire logic             CRUISE_ACTIVE,
	input  wire logic [SPD_W-1:0] CRUISE_SET_SPEED,
	// Auxiliary drive state.
	input  wire logic             AUX_DRIVE_ACTIVE_INPUT,
	input  wire logic [1:0]       AUX_DRIVE_CFG,
	// Programmed options.
	input  wire logic [1:0]       BRAKE_MODE,
	input  wire logic             AUTO_CRUISE_EN,
	input  wire logic [SPD_W-1:0] MIN_VEH_SPEED,
	input  wire logic [SPD_W-1:0] OVERSPEED_OFS,
	input  wire logic [SPD_W-1:0] SPEED_INC,
	input  wire logic [DLY_W-1:0] DELAY_TICKS,
	// Brake outputs.
	output logic [1:0]            BRAKE_LEVEL,
	output logic [2:0]            SOL_DRIVE,
	output logic                  AUX_BRAKE_EN
);

	// ======================================================================
	// Elaboration checks.
	// ======================================================================
	// The rpm field must hold the threshold; other widths must be positive.
	if (RPM_W < 10 || SPD_W < 1 || DLY_W < 1)
		$error("widths too narrow for thresholds, speeds or delays");
	localparam logic [RPM_W-1:0] RPM_MIN_W = RPM_W'(eb_pkg::RPM_MIN);
	localparam logic [SPD_W-1:0] SPD_STILL = SPD_W'(eb_pkg::SPEED_STILL);

	// ======================================================================
	// Functions.
	// ======================================================================
	// Lower of two levels; level codes are ordered by strength.
	function automatic logic [1:0] min_lvl(input logic [1:0] a,
		input logic [1:0] b);
		min_lvl = (a < b) ? a : b;
	endfunction

	// Solenoid pattern for a level.
	function automatic logic [2:0] sol_of(input logic [1:0] lvl);
		case (lvl)
			eb_pkg::LVL_LOW:  sol_of = eb_pkg::SOL_LOW;
			eb_pkg::LVL_MED:  sol_of = eb_pkg::SOL_MED;
			eb_pkg::LVL_HIGH: sol_of = eb_pkg::SOL_HIGH;
			default:          sol_of = eb_pkg::SOL_OFF;
		endcase
	endfunction

	// Level asked for by the overspeed above the cruise set speed. The
	// sums are two bits wider so a large offset cannot wrap around.
	function automatic logic [1:0] auto_lvl(
		input logic [SPD_W-1:0] spd,
		input logic [SPD_W-1:0] set,
		input logic [SPD_W-1:0] ofs,
		input logic [SPD_W-1:0] inc);
		logic [SPD_W+1:0] sp, t_low, t_med, t_high;
		sp     = {2'h0, spd};
		t_low  = {2'h0, set} + {2'h0, ofs};
		t_med  = t_low + {2'h0, inc};
		t_high = t_med + {2'h0, inc};
		if (sp > t_high)
			auto_lvl = eb_pkg::LVL_HIGH;
		else if (sp > t_med)
			auto_lvl = eb_pkg::LVL_MED;
		else if (sp > t_low)
			auto_lvl = eb_pkg::LVL_LOW;
		else
			auto_lvl = eb_pkg::LVL_OFF;
	endfunction

	// ======================================================================
	// Internal signals.
	// ======================================================================
	logic             [1:0] sel_lvl, req_lvl;
	logic                   base_ok, spd_inhibit, aux_inhibit, permit;
	logic                   eng_want, aux_want, eng_fire, aux_fire;
	logic                   modes_apply, hold_release;
	eb_pkg::hold_st_t       hold_st_ff, nxt_hold_st;
	logic             [1:0] level_ff;
	logic             [2:0] sol_ff;
	logic                   aux_ff, want_prev_ff;

	// ======================================================================
	// Switch decode and permission.
	// ======================================================================
	// Low switch carries bit 0 and medium bit 1 of the level code.
	assign sel_lvl = {SW_MED_SHORT, SW_LOW_SHORT};
	// Base conditions hold whatever the programmed options are.
	assign base_ok = (ENGINE_RPM > RPM_MIN_W) &&
		(PEDAL_PCT < eb_pkg::PEDAL_MAX_PCT) &&
		!CLUTCH_PRESSED;
	// A minimum of zero never inhibits, since no speed lies below it.
	assign spd_inhibit = (MIN_VEH_SPEED != SPD_STILL) &&
		(VEH_SPEED > SPD_STILL) &&
		(VEH_SPEED < MIN_VEH_SPEED);
	// An active auxiliary drive with any configuration other than none blocks braking.
	assign aux_inhibit = AUX_DRIVE_ACTIVE_INPUT &&
		(AUX_DRIVE_CFG != eb_pkg::AUX_CFG_NONE);
	// Fueling blocks every activation this block would start itself.
	assign permit = base_ok && !spd_inhibit && !aux_inhibit &&
		!FUELING;
	// Initiation modes govern only with the switch on and cruise idle.
	assign modes_apply = CRUISE_SW_ON && !CRUISE_ACTIVE;

	// ======================================================================
	// Brake-triggered hold latch.
	// ======================================================================
	// Throttle counts as pressed once the pedal reaches the threshold.
	assign hold_release = (PEDAL_PCT >= eb_pkg::PEDAL_MAX_PCT) ||
		CLUTCH_PRESSED || (ENGINE_RPM < RPM_MIN_W) ||
		!modes_apply || (BRAKE_MODE != eb_pkg::MODE_HOLD);

	// Next latch state; leaving the mode or cruise also drops it.
	always_comb
	begin
		nxt_hold_st = hold_st_ff;
		case (hold_st_ff)
			eb_pkg::HOLD_IDLE:
				if (!hold_release && SERVICE_BRAKE && permit)
					nxt_hold_st = eb_pkg::HOLD_SET;
			eb_pkg::HOLD_SET:
				if (hold_release)
					nxt_hold_st = eb_pkg::HOLD_IDLE;
			default:
				nxt_hold_st = eb_pkg::HOLD_IDLE;
		endcase
	end

	// Latch state moves only on the control tick.
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			hold_st_ff <= eb_pkg::HOLD_IDLE;
		else if (TICK)
			hold_st_ff <= nxt_hold_st;
	end

	// ======================================================================
	// Requested level.
	// ======================================================================
	// Active cruise uses automatic braking only; without it the engine
	// brake stays off, as a brake press has already cancelled cruise.
	always_comb
	begin
		req_lvl = eb_pkg::LVL_OFF;
		if (CRUISE_ACTIVE)
			req_lvl = AUTO_CRUISE_EN ? min_lvl(sel_lvl,
				auto_lvl(VEH_SPEED, CRUISE_SET_SPEED,
				OVERSPEED_OFS, SPEED_INC)) : eb_pkg::LVL_OFF;
		else if (CRUISE_SW_ON)
		begin
			case (BRAKE_MODE)
				eb_pkg::MODE_FOLLOW:
					if (SERVICE_BRAKE)
						req_lvl = sel_lvl;
				eb_pkg::MODE_HOLD:
					if (SERVICE_BRAKE ||
						hold_st_ff == eb_pkg::HOLD_SET)
						req_lvl = sel_lvl;
				default:
					req_lvl = sel_lvl;
			endcase
		end
		else
			req_lvl = sel_lvl;
	end

	assign eng_want = permit && (req_lvl != eb_pkg::LVL_OFF);

	// Auxiliary brake: base conditions, a brake press while the cruise
	// switch is on, and never during active cruise.
	assign aux_want = base_ok && !aux_inhibit && !FUELING &&
		!CRUISE_ACTIVE &&
		(!CRUISE_SW_ON || SERVICE_BRAKE);

	// ======================================================================
	// Engagement delays.
	// ======================================================================
	engage_delay #(.DLY_W (DLY_W))
	u_eng_delay
	(
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.tick  (TICK),
		.want  (eng_want),
		.delay (DELAY_TICKS),
		.fire  (eng_fire)
	);

	engage_delay #(.DLY_W (DLY_W))
	u_aux_delay
	(
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.tick  (TICK),
		.want  (aux_want),
		.delay (DELAY_TICKS),
		.fire  (aux_fire)
	);

	// ======================================================================
	// Output registers.
	// ======================================================================
	// Level and solenoids change together, so they never disagree. A
	// level change while engaged takes effect at once, with no delay.
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			level_ff <= eb_pkg::LVL_OFF;
			sol_ff   <= eb_pkg::SOL_OFF;
		end
		else if (TICK)
		begin
			level_ff <= eng_fire ? req_lvl : eb_pkg::LVL_OFF;
			sol_ff   <= sol_of(eng_fire ? req_lvl : eb_pkg::LVL_OFF);
		end
	end
	// Auxiliary brake drives high to brake and drops on the failing tick.
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			aux_ff <= 1'b0;
		else if (TICK)
			aux_ff <= aux_fire;
	end
	// Request seen on the previous tick, for the delay check only.
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			want_prev_ff <= 1'b0;
		else if (TICK)
			want_prev_ff <= eng_want;
	end

	assign BRAKE_LEVEL  = level_ff;
	assign SOL_DRIVE    = sol_ff;
	assign AUX_BRAKE_EN = aux_ff;

	// ======================================================================
	// Assertions.
	// ======================================================================
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	// Outputs show the off level on the next cycle.
	sequence s_off_next;
		##1 (BRAKE_LEVEL == eb_pkg::LVL_OFF) &&
			(SOL_DRIVE == eb_pkg::SOL_OFF);
	endsequence
	// Follow mode with cruise switch on, idle, and the brake let go.
	sequence s_follow_released;
		TICK && modes_apply && !SERVICE_BRAKE &&
			(BRAKE_MODE == eb_pkg::MODE_FOLLOW);
	endsequence
	property p_sol_matches;
		SOL_DRIVE == sol_of(BRAKE_LEVEL);
	endproperty
	a_sol_matches: assert property (p_sol_matches)
		else $error("solenoids disagree with level");
	property p_base_off;
		TICK && !base_ok |-> s_off_next;
	endproperty
	a_base_off: assert property (p_base_off)
		else $error("brake on without base conditions");
	property p_speed_off;
		TICK && spd_inhibit |-> s_off_next;
	endproperty
	a_speed_off: assert property (p_speed_off)
		else $error("brake on below minimum speed");
	property p_aux_drive_off;
		TICK && aux_inhibit |=> !AUX_BRAKE_EN &&
			(BRAKE_LEVEL == eb_pkg::LVL_OFF);
	endproperty
	a_aux_drive_off: assert property (p_aux_drive_off)
		else $error("brake on with auxiliary drive active");
	property p_follow_release;
		s_follow_released |-> s_off_next;
	endproperty
	a_follow_release: assert property (p_follow_release)
		else $error("follow mode held brake after release");
	property p_hold_clear;
		TICK && (hold_st_ff == eb_pkg::HOLD_SET) &&
			(CLUTCH_PRESSED || ENGINE_RPM < RPM_MIN_W) |=>
			hold_st_ff == eb_pkg::HOLD_IDLE;
	endproperty
	a_hold_clear: assert property (p_hold_clear)
		else $error("hold latch not released");
	property p_switch_cap;
		TICK |=> BRAKE_LEVEL <= $past(sel_lvl);
	endproperty
	a_switch_cap: assert property (p_switch_cap)
		else $error("level above switch selection");
	property p_cruise_no_aux;
		TICK && CRUISE_ACTIVE |=> !AUX_BRAKE_EN;
	endproperty
	a_cruise_no_aux: assert property (p_cruise_no_aux)
		else $error("auxiliary brake on in active cruise");
	property p_delay_first;
		TICK && eng_want && !want_prev_ff &&
			(DELAY_TICKS != '0) |-> s_off_next;
	endproperty
	a_delay_first: assert property (p_delay_first)
		else $error("brake engaged without delay");
	property p_fuel_off;
		TICK && FUELING |=> !AUX_BRAKE_EN &&
			(BRAKE_LEVEL == eb_pkg::LVL_OFF);
	endproperty
	a_fuel_off: assert property (p_fuel_off)
		else $error("brake on while fueling");
	property p_release_now;
		TICK && !eng_want |-> s_off_next;
	endproperty
	a_release_now: assert property (p_release_now)
		else $error("brake not released on failing tick");
	property p_hold_between_ticks;
		!TICK |=> $stable(BRAKE_LEVEL) && $stable(AUX_BRAKE_EN);
	endproperty
	a_hold_between_ticks: assert property (p_hold_between_ticks)
		else $error("outputs changed off tick");

endmodule

// *** testbench/cab_side_model.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Cab side: level selector contacts and the three brake solenoid coils.
// ==========================================================================
module cab_side_model
(
	// Level the driver has dialled in on the selector.
	input  wire logic [1:0] dial,
	// Contacts, high while shorted to sensor common.
	output logic            sw_low_short,
	output logic            sw_med_short,
	// Solenoid coils, and whether they show one of the four levels.
	input  wire logic [2:0] sol,
	output logic            sol_ok
);
	// The low contact closes for low and high, the medium one for medium
	// and high, so both open means off.
	assign sw_low_short = dial[0];
	assign sw_med_short = dial[1];

	// Any coil mix outside the four levels would be a half-applied brake.
	assign sol_ok = sol inside {eb_pkg::SOL_OFF, eb_pkg::SOL_LOW,
		eb_pkg::SOL_MED, eb_pkg::SOL_HIGH};
endmodule

// *** testbench/brake_level_ctrl_test.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Comparison helper.
// ==========================================================================
`define CHK(n, a, b) begin checked++; if ((a) !== (b)) begin errors++; \
	$display("BAD %s exp %0h got %0h", n, b, a); end end

module brake_level_ctrl_test;
	// ======================================================================
	// Stimulus, staged by the tests and applied at the next rising edge.
	// ======================================================================
	typedef struct packed
	{
		logic        rst_n, tick, clutch, brake, fuel;
		logic        cr_sw, cr_act, aux_in, auto_en;
		logic [1:0]  sw, cfg, mode;
		logic [15:0] rpm;
		logic [7:0]  pedal, spd, set, minspd, ofs, inc, dly;
	} stim_t;

	stim_t      s = '0;
	stim_t      p = '0;
	logic       clk = 1'b0;
	logic       tick_seen = 1'b0;
	logic       live = 1'b0;
	logic [2:0] e = '0;
	logic [2:0] q[$];
	logic [2:0] seq[8] = '{3'h4, 3'h0, 3'h0, 3'h2, 3'h0, 3'h4, 3'h1, 3'h0};
	int         errors = 0;
	int         checked = 0;
	int         cnt_e = 0;
	int         cnt_a = 0;
	bit         latch = 1'b0;
	logic       sw_low, sw_med, sol_ok;
	logic [1:0] lvl;
	logic [2:0] sol;
	logic       aux;

	// ======================================================================
	// Clock, input staging and the design with its cab side.
	// ======================================================================
	always #4 clk = ~clk;

	// Staging keeps every input change on the rising edge.
	always @(posedge clk)
	begin
		p <= s;
		tick_seen <= p.tick;
		live <= 1'b1;
	end

	cab_side_model u_cab_side_model
	(
		.dial(p.sw), .sw_low_short(sw_low), .sw_med_short(sw_med),
		.sol(sol), .sol_ok(sol_ok)
	);

	brake_level_ctrl u_brake_level_ctrl
	(
		.REF_CLK(clk), .RST_N(p.rst_n), .TICK(p.tick),
		.SW_LOW_SHORT(sw_low), .SW_MED_SHORT(sw_med),
		.ENGINE_RPM(p.rpm), .PEDAL_PCT(p.pedal),
		.CLUTCH_PRESSED(p.clutch), .SERVICE_BRAKE(p.brake),
		.FUELING(p.fuel), .VEH_SPEED(p.spd), .CRUISE_SW_ON(p.cr_sw),
		.CRUISE_ACTIVE(p.cr_act), .CRUISE_SET_SPEED(p.set),
		.AUX_DRIVE_ACTIVE_INPUT(p.aux_in), .AUX_DRIVE_CFG(p.cfg),
		.BRAKE_MODE(p.mode), .AUTO_CRUISE_EN(p.auto_en),
		.MIN_VEH_SPEED(p.minspd), .OVERSPEED_OFS(p.ofs),
		.SPEED_INC(p.inc), .DELAY_TICKS(p.dly),
		.BRAKE_LEVEL(lvl), .SOL_DRIVE(sol), .AUX_BRAKE_EN(aux)
	);

	// ======================================================================
	// Reference behaviour, evaluated once per tick from the staged inputs.
	// ======================================================================
	function automatic logic [2:0] sol_of(logic [1:0] l);
		case (l)
			eb_pkg::LVL_OFF: return eb_pkg::SOL_OFF;
			eb_pkg::LVL_LOW: return eb_pkg::SOL_LOW;
			eb_pkg::LVL_MED: return eb_pkg::SOL_MED;
			default:         return eb_pkg::SOL_HIGH;
		endcase
	endfunction

	// Saturating engagement count; true once the wait has run out.
	function automatic bit fire(bit w, ref int c);
		if (!w)
			c = 0;
		else if (c < s.dly)
			c++;
		else
			return 1'b1;
		return 1'b0;
	endfunction

	// Works out the expected outputs of the coming tick and notes them.
	task automatic predict();
		int thr, aut, req;
		bit ok, aw, fe, fa;
		ok = s.rpm > 800 && s.pedal < 7 && !s.clutch && !s.fuel
			&& !(s.minspd != 0 && s.spd > 0 && s.spd < s.minspd)
			&& !(s.aux_in && s.cfg != eb_pkg::AUX_CFG_NONE);
		thr = s.set + s.ofs;
		aut = s.spd > thr + 2 * s.inc ? 3 : s.spd > thr + s.inc ? 2 : s.spd > thr;
		if (s.cr_act)
			req = s.auto_en ? (aut < s.sw ? aut : s.sw) : 0;
		else if (s.cr_sw && s.mode == eb_pkg::MODE_FOLLOW)
			req = s.brake ? s.sw : 0;
		else if (s.cr_sw && s.mode == eb_pkg::MODE_HOLD)
			req = (s.brake || latch) ? s.sw : 0;
		else
			req = s.sw;
		latch = (s.pedal >= 7 || s.clutch || s.rpm < 800 || !s.cr_sw
			|| s.cr_act || s.mode != eb_pkg::MODE_HOLD) ? 1'b0
			: (latch || (s.brake && ok));
		aw = s.rpm > 800 && s.pedal < 7 && !s.clutch && !s.fuel && !s.cr_act
			&& !(s.aux_in && s.cfg != 0) && (!s.cr_sw || s.brake);
		fe = fire(ok && req != 0, cnt_e);
		fa = fire(aw, cnt_a);
		q.push_back({fa, fe ? 2'(req) : 2'h0});
	endtask

	// Applies the staged inputs with a tick, n times over.
	task automatic tk(int n = 1);
		repeat (n)
		begin
			predict();
			s.tick = 1'b1;
			@(posedge clk);
			#1 s.tick = 1'b0;
			@(posedge clk);
			#1;
		end
	endtask

	// Plain driving conditions with every brake permission met.
	task automatic base();
		s = '0;
		s.rst_n = 1'b1;
		s.rpm = 16'(801 + $urandom % 2000);
		s.pedal = 8'($urandom % 7);
		s.sw = 2'h3;
		s.mode = eb_pkg::MODE_SWITCH;
	endtask

	// ======================================================================
	// Output watcher: takes the oldest note after each tick, and checks
	// that outputs stand unchanged between ticks as well.
	// ======================================================================
	always @(negedge clk)
	begin
		if (tick_seen)
		begin
			if (q.size() == 0)
			begin
				errors++;
				$display("BAD note queue exp 1 got 0");
			end
			else
				e = q.pop_front();
		end
		if (live)
		begin
			`CHK("level", lvl, e[1:0])
			`CHK("solenoids", sol, sol_of(e[1:0]))
			`CHK("aux brake", aux, e[2])
			`CHK("coil pattern", sol_ok, 1'b1)
		end
	end

	// ======================================================================
	// Verdict.
	// ======================================================================
	task automatic close_out();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// The tests need a few hundred cycles; this leaves ample margin.
	initial
	begin
		#(3000 * 8);
		errors++;
		close_out();
	end

	// ======================================================================
	// Tests.
	// ======================================================================
	initial
	begin
		void'($urandom(29971));
		repeat (4) @(posedge clk);
		#1;
		base();
		// Every selector code, then a fresh engagement waiting two ticks.
		for (int i = 0; i < 4; i++)
		begin
			s.sw = 2'(i);
			tk(2);
		end
		s.sw = 2'h0;
		tk();
		s.dly = 8'h02;
		s.sw = 2'h3;
		tk(4);
		$display("test selector done");
		// Rpm, pedal, clutch and fueling each just failed, and rpm and pedal just met, one at a time.
		for (int i = 0; i < 6; i++)
		begin
			base();
			case (i)
				0: s.rpm = 16'h0320;
				1: s.pedal = 8'h07;
				2: s.clutch = 1'b1;
				3: s.fuel = 1'b1;
				4: s.rpm = 16'h0321;
				default: s.pedal = 8'h06;
			endcase
			tk(2);
		end
		$display("test permission done");
		// Standing, below, at and above the minimum, then check disabled.
		base();
		s.minspd = 8'h14;
		for (int i = 0; i < 5; i++)
		begin
			s.spd = 8'(i == 0 ? 0 : (i == 4 ? 5 : 18 + i));
			if (i == 4)
				s.minspd = 8'h00;
			tk(2);
		end
		$display("test minimum speed done");
		// Auxiliary drive input active under each configuration code.
		base();
		s.aux_in = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			s.cfg = 2'(i);
			tk(2);
		end
		$display("test aux drive done");
		// Brake press, release, throttle, press again, low rpm per mode.
		base();
		s.cr_sw = 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			s.mode = 2'(m);
			foreach (seq[k])
			begin
				s.brake = seq[k][2];
				s.pedal = seq[k][1] ? 8'h0a : 8'h00;
				s.rpm = seq[k][0] ? 16'h02bc : 16'h05dc;
				tk();
			end
		end
		$display("test modes done");
		// Overspeed steps under active cruise, capped by the selector.
		base();
		s.cr_sw = 1'b1;
		s.cr_act = 1'b1;
		s.set = 8'h32;
		s.ofs = 8'h03;
		s.inc = 8'h02;
		for (int i = 0; i < 30; i++)
		begin
			s.auto_en = i < 20;
			s.sw = 2'(3 - i / 10);
			s.spd = 8'(52 + i % 10);
			tk();
		end
		$display("test auto cruise done");
		// Delayed engagement of both outputs, drop, and a full new wait.
		base();
		s.dly = 8'h03;
		s.cr_sw = 1'b1;
		s.brake = 1'b1;
		tk(5);
		s.clutch = 1'b1;
		tk();
		s.clutch = 1'b0;
		tk(5);
		$display("test delay done");
		close_out();
	end
endmodule
